// >>> core/pcb_ctrl.v
// Functional notes
// - auto offset on and prox running: zero result decrements matching nonzero offset by one.
// - each automatic offset decrement sets offset-adjusted flag, may raise calibration irq.
// - auto baseline on (reset): lower baseline to average when average is smaller.
// - each automatic baseline lowering sets baseline-adjusted flag, may raise irq.
// - average count field: n gives 2^n results (0 passes each result through); resets to 4.
// - each completed averaging run stores a 14-bit average, unless PCB_ADDR_CFG_ONE is written in that cycle.
// - search target equals 2^(field+2)-1, field in bits 7:5.
// - calibration irq asserted for these events only when enabled.
// - adjusted flags stay set until host writes one to their bit.
`include "pcb_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module pcb_ctrl (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        prox_run_i,
    input  wire        calibration_irq_en_i,
    input  wire        result_valid_i,
    input  wire [13:0] result_i,
    input  wire        result_chan_i,
    output reg  [8:0]  offset0_o,
    output reg  [8:0]  offset1_o,
    output reg  [13:0] prox_average_o,
    output reg         average_valid_o,
    output reg  [13:0] prox_baseline_o,
    output reg  [8:0]  search_target_o,
    output wire        subtract_baseline_one_o,
    output wire        subtract_baseline_zero_o,
    output wire        calibration_irq_o
);
    reg  [7:0]  cfg_one_q;
    reg  [7:0]  cfg_two_q;
    reg         offs_adj_q;
    reg         bsln_adj_q;
    reg  [21:0] acc_q;
    reg  [7:0]  cnt_q;
    wire        auto_offset_decrement_en = cfg_one_q[`PCB_BIT_AUTO_OFFSET];
    wire        auto_baseline_lower_en   = cfg_one_q[`PCB_BIT_AUTO_BSLN];
    wire [2:0]  average_count_sel =
                cfg_one_q[`PCB_AVG_SEL_MSB:`PCB_AVG_SEL_LSB];
    wire [2:0]  search_target_sel =
                cfg_two_q[`PCB_TGT_SEL_MSB:`PCB_TGT_SEL_LSB];
    wire        wr_one = reg_wr_i && reg_addr_i == `PCB_ADDR_CFG_ONE;
    wire        wr_two = reg_wr_i && reg_addr_i == `PCB_ADDR_CFG_TWO;
    wire        wr_st  = reg_wr_i && reg_addr_i == `PCB_ADDR_STATUS;
    wire        take   = result_valid_i && prox_run_i;
    wire        zero_hit = take && auto_offset_decrement_en &&
                           result_i == 14'h0000;
    wire        dec0 = zero_hit && !result_chan_i &&
                       offset0_o != 9'h000;
    wire        dec1 = zero_hit && result_chan_i &&
                       offset1_o != 9'h000;
    wire [7:0]  run_len = 8'h01 << average_count_sel;
    wire [21:0] acc_sum = acc_q + {8'h00, result_i};
    wire        run_done = take && (cnt_q + 8'h01 == run_len);
    wire [13:0] avg_now = (average_count_sel == 3'h0) ? result_i :
                          acc_sum[13 + average_count_sel -: 14];
    wire        lower = run_done && auto_baseline_lower_en &&
                        avg_now < prox_baseline_o;
    assign subtract_baseline_one_o  = cfg_one_q[`PCB_BIT_SUB_BSLN_ONE];
    assign subtract_baseline_zero_o = cfg_one_q[`PCB_BIT_SUB_BSLN_ZERO];
    assign calibration_irq_o = calibration_irq_en_i &&
                               (offs_adj_q || bsln_adj_q);
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_one_q       <= `PCB_CFG_ONE_RST;
            cfg_two_q       <= `PCB_CFG_TWO_RST;
            offs_adj_q      <= 1'b0;
            bsln_adj_q      <= 1'b0;
            // offsets start mid-range so zero results can walk them down
            offset0_o       <= `PCB_OFFSET_RST;
            offset1_o       <= `PCB_OFFSET_RST;
            acc_q           <= 22'h000000;
            cnt_q           <= 8'h00;
            prox_average_o  <= 14'h0000;
            average_valid_o <= 1'b0;
            prox_baseline_o <= `PCB_BSLN_RST;
            search_target_o <= 9'h000;
        end else begin
            if (wr_one) begin
                cfg_one_q <= reg_wdata_i & `PCB_CFG_ONE_MASK;
            end
            if (wr_two) begin
                cfg_two_q <= reg_wdata_i & `PCB_CFG_TWO_MASK;
            end
            search_target_o <= (9'h004 << search_target_sel) - 9'h001;
            if (dec0) begin
                offset0_o <= offset0_o - `PCB_OFFSET_STEP;
            end
            if (dec1) begin
                offset1_o <= offset1_o - `PCB_OFFSET_STEP;
            end
            // set wins over a simultaneous write-one clear
            if (dec0 || dec1) begin
                offs_adj_q <= 1'b1;
            end else if (wr_st && reg_wdata_i[`PCB_BIT_OFFS_ADJ]) begin
                offs_adj_q <= 1'b0;
            end
            if (lower) begin
                bsln_adj_q <= 1'b1;
                prox_baseline_o <= avg_now;
            end else if (wr_st && reg_wdata_i[`PCB_BIT_BSLN_ADJ]) begin
                bsln_adj_q <= 1'b0;
            end
            average_valid_o <= run_done;
            if (!prox_run_i || wr_one) begin
                acc_q <= 22'h000000;
                cnt_q <= 8'h00;
            end else if (run_done) begin
                acc_q <= 22'h000000;
                cnt_q <= 8'h00;
                prox_average_o <= avg_now;
            end else if (take) begin
                acc_q <= acc_sum;
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    always @* begin
        case (reg_addr_i)
            `PCB_ADDR_CFG_ONE: reg_rdata_o = cfg_one_q;
            `PCB_ADDR_CFG_TWO: reg_rdata_o = cfg_two_q;
            `PCB_ADDR_STATUS:  reg_rdata_o = {5'h00, bsln_adj_q,
                                              offs_adj_q, 1'b0};
            default:           reg_rdata_o = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

// >>> core/pcb_defines.vh
`ifndef PCB_DEFINES_VH
`define PCB_DEFINES_VH
`define PCB_ADDR_CFG_ONE      8'h6B
`define PCB_ADDR_CFG_TWO      8'h6C
`define PCB_ADDR_STATUS       8'h6D
`define PCB_BIT_AUTO_OFFSET   6
`define PCB_BIT_SUB_BSLN_ONE  5
`define PCB_BIT_SUB_BSLN_ZERO 4
`define PCB_BIT_AUTO_BSLN     3
`define PCB_AVG_SEL_MSB       2
`define PCB_AVG_SEL_LSB       0
`define PCB_TGT_SEL_MSB       7
`define PCB_TGT_SEL_LSB       5
`define PCB_BIT_BSLN_ADJ      2
`define PCB_BIT_OFFS_ADJ      1
`define PCB_CFG_ONE_MASK      8'h7F
`define PCB_CFG_TWO_MASK      8'hE0
`define PCB_CFG_ONE_RST       8'h0C
`define PCB_CFG_TWO_RST       8'h00
`define PCB_OFFSET_STEP       9'h001
`define PCB_OFFSET_RST        9'h100
`define PCB_BSLN_RST          14'h3FFF
`endif

// >>> verif/pcb_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_chk (
    input wire logic        clk_i, sys_rst_i, reg_wr_i, prox_run_i,
    input wire logic        calibration_irq_en_i, result_valid_i,
    input wire logic        average_valid_o, calibration_irq_o,
    input wire logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic [8:0]  offset0_o, search_target_o,
    input wire logic [13:0] result_i, prox_average_o, prox_baseline_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_irq_gate: assert property (
        calibration_irq_o |-> calibration_irq_en_i) else $error("irq on");
    chk_target_val: assert property (
        reg_wr_i && reg_addr_i == 8'h6C |-> ##2 search_target_o ==
        (10'h004 << $past(reg_wdata_i[7:5], 2)) - 10'h001)
        else $error("target");
    chk_offset_step: assert property (
        $changed(offset0_o) |-> $past(result_valid_i && !result_i)
        && offset0_o == $past(offset0_o) - 9'h001) else $error("offset");
    chk_base_low: assert property (
        $changed(prox_baseline_o) |-> average_valid_o
        && prox_baseline_o == prox_average_o) else $error("baseline");
    chk_avg_cause: assert property (
        average_valid_o |-> $past(result_valid_i && prox_run_i))
        else $error("average");
    chk_flag_irq: assert property (
        ($changed(offset0_o) || $changed(prox_baseline_o))
        && calibration_irq_en_i |-> calibration_irq_o) else $error("irq");
    chk_flag_hold: assert property (
        calibration_irq_o && !reg_wr_i |=> calibration_irq_o
        || !calibration_irq_en_i) else $error("flag lost");
    chk_rsvd_zero: assert property (
        reg_addr_i == 8'h6C |-> reg_rdata_o[4:0] == 5'h00) else $error("rsvd");
    cov_avg: cover property (average_valid_o && prox_average_o != 14'h0000);
    cov_base: cover property ($changed(prox_baseline_o));
    cov_clear: cover property (calibration_irq_o ##1 !calibration_irq_o);
endmodule
bind pcb_ctrl pcb_chk pcb_chk_i (.*);
`default_nettype wire

// >>> verif/pcb_host.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_host (
    input  wire logic       clk_i,
    output var  logic       wr_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] data_o
);
    initial {wr_o, addr_o, data_o} = 17'h00000;
    // w low: address only, data settles by the next falling edge
    task automatic wr(input logic [7:0] a, d, input logic w = 1'b1);
        @(negedge clk_i) {wr_o, addr_o, data_o} = {w, a, d};
        @(negedge clk_i) wr_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/pcb_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module pcb_ctrl_test;
    logic        clk_i = 1'b0, sys_rst_i, prox_run_i, calibration_irq_en_i;
    logic        reg_wr_i, result_valid_i, result_chan_i, average_valid_o;
    logic        calibration_irq_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rnd = 8'h26;
    logic [8:0]  offset0_o, offset1_o, search_target_o;
    logic        subtract_baseline_one_o, subtract_baseline_zero_o;
    logic [13:0] result_i, prox_average_o, prox_baseline_o, bsln = 14'h3FFF;
    logic [27:0] exp_q[$];
    int          n_fail = 0, comparisons = 0;
    pcb_host pcb_host_i (.clk_i, .wr_o(reg_wr_i), .addr_o(reg_addr_i),
        .data_o(reg_wdata_i));
    pcb_ctrl pcb_ctrl_i (.*);
    initial forever #10 clk_i = ~clk_i;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string n, input logic [27:0] e, s);
        comparisons++;
        if (e !== s) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    always @(negedge clk_i) if (average_valid_o === 1'b1)
        chk("average", exp_q.pop_front(),
            {prox_average_o, prox_baseline_o});
    task automatic rdc(input logic [7:0] a, e);
        pcb_host_i.wr(a, 8'h00, 1'b0);
        chk("register", e, reg_rdata_o);
    endtask
    task automatic run(input logic [7:0] cfg, input int n);
        logic [21:0] sum;
        sum = 22'h0;
        pcb_host_i.wr(8'h6B, cfg);
        repeat (n) begin
            @(negedge clk_i) result_valid_i = 1'b1;
            result_i = cfg[6] ? 14'h0000 : {6'h00, rnd};
            sum += result_i;
            rnd = lfsr(rnd);
        end
        sum = sum >> cfg[2:0];
        if (cfg[3] && sum < bsln) bsln = sum[13:0];
        exp_q.push_back({sum[13:0], bsln});
        @(negedge clk_i) result_valid_i = 1'b0;
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        {sys_rst_i, prox_run_i, calibration_irq_en_i} = 3'b111;
        {result_valid_i, result_chan_i, result_i} = 16'h0000;
        repeat (16) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rdc(8'h6B, 8'h0C);
        chk("baseline", 14'h3FFF, prox_baseline_o);
        for (int k = 0; k < 8; k++) begin
            pcb_host_i.wr(8'h6C, {k[2:0], 5'h1F});
            @(negedge clk_i);
            chk("target", (10'h004 << k) - 1, search_target_o);
            run({5'h11, k[2:0]}, 1 << k);
            rdc(8'h6B, {5'h01, k[2:0]});
        end
        chk("irq", 1'b1, calibration_irq_o);
        calibration_irq_en_i = 1'b0;
        rdc(8'h6D, 8'h04);
        chk("irq", 1'b0, calibration_irq_o);
        calibration_irq_en_i = 1'b1;
        pcb_host_i.wr(8'h6D, 8'h04);
        rdc(8'h6D, 8'h00);
        pcb_host_i.wr(8'h6B, 8'h30);
        chk("subtract", 2'b11, {subtract_baseline_one_o,
            subtract_baseline_zero_o});
        run(8'h02, 4);
        chk("offset", 9'h100, offset0_o);
        run(8'h41, 2);
        rdc(8'h6D, 8'h02);
        chk("irq", 1'b1, calibration_irq_o);
        chk("offset", 9'h0FE, offset0_o);
        chk("offset1", 9'h100, offset1_o);
        chk("pending", 28'h0, exp_q.size());
        print_verdict();
    end
endmodule
`default_nettype wire
